// [design/cfr_pkg.sv]
// constants for the channel filter configuration register set
package cfr_pkg;
	localparam logic [7:0] ADDR_INTERP = 8'h91;
	localparam logic [7:0] ADDR_RSCALE = 8'h92;
	localparam logic [7:0] ADDR_RSVD_A = 8'h93;
	localparam logic [7:0] ADDR_CDEC = 8'h94;
	localparam logic [7:0] ADDR_CSCALE = 8'h95;
	localparam logic [7:0] ADDR_RSVD_B = 8'h96;
	localparam logic [7:0] ADDR_FDEC = 8'hA0;
	localparam logic [7:0] ADDR_FPHASE = 8'hA1;
	localparam logic [7:0] ADDR_FTAPS = 8'hA2;
	localparam logic [7:0] ADDR_FOFFS = 8'hA3;
	localparam logic [7:0] ADDR_FCTRL = 8'hA4;
	localparam logic [7:0] ADDR_CAP_I = 8'hA5;
	localparam logic [7:0] ADDR_CAP_Q = 8'hA6;
	localparam logic [7:0] ADDR_STCNT = 8'hA7;
	localparam logic [7:0] ADDR_MEMST = 8'hA8;
	localparam int RSC_POL_BIT = 11;
	localparam int RSC_WEIGHT_BIT = 10;
	localparam int RSC_HI_MSB = 9;
	localparam int RSC_HI_LSB = 5;
	localparam int RSC_LO_MSB = 4;
	localparam int RSC_LO_LSB = 0;
	localparam int CTL_BYPASS_BIT = 10;
	localparam int CTL_XSRC_BIT = 9;
	localparam int CTL_COEFFICIENT_MEMORY_HALF_BIT = 8;
	localparam int CTL_SHARED_EXP_BIT = 7;
	localparam int CTL_FORCE_SCALE_BIT = 6;
	localparam int CTL_FMT_MSB = 5;
	localparam int CTL_FMT_LSB = 4;
	localparam int CTL_SCALE_MSB = 3;
	localparam int CTL_SCALE_LSB = 0;
	localparam int SER_MAP_BIT = 9;
	localparam int MST_START_BIT = 0;
	localparam int MST_COEFFICIENT_MEMORY_FAIL_BIT = 1;
	localparam int MST_DMEM_FAIL_BIT = 2;
	localparam int MEMTEST_NS = 160000;
	localparam int CLK_NS = 100;
	localparam int MEMTEST_CYCLES = MEMTEST_NS / CLK_NS;
	localparam logic [15:0] MEMTEST_CNT = 16'(MEMTEST_CYCLES);
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 32;
	localparam logic [1:0] FMT_FIXED = 2'h0;
	localparam logic [1:0] FMT_8P4 = 2'h1;
	localparam int CH_COUNT = 4;
	typedef enum logic [1:0] {MT_IDLE, MT_RUN} cfr_mt_state_t;
endpackage : cfr_pkg

// [design/cfr_fifo.sv]
// small valid/ready fifo used in the capture data path
`timescale 1ns/1ns
`default_nettype none
module cfr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_r];
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : cfr_fifo
`default_nettype wire

// [design/cfr_regs.sv]
// channel filter configuration and observation registers
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - interpolation register holds factor minus one, factors 1 to 512
// - resampler scale bit 11 selects input exponent polarity
// - resampler scale bit 10 selects 6.02 or 12.02 dB exponent step
// - scale bits 9-5 used while level indicator active, 4-0 otherwise
// - comb decimation is 8 bits minus one; above 32 is out of range
// - filter decimation 8 bits minus one, up to 256
// - phase may change anytime, loaded at each filter start, kept through sync
// - tap count register holds taps minus one
// - coefficient offset shadowed, copied to pointer when a filter starts
// - control bit 10 bypasses filter, comb output goes to capture registers
// - control bit 9 takes comb input from another channel per fixed table
// - control bit 8 picks coefficient memory half for writes only
// - bit 7 selects shared or independent exponents in float formats
// - bit 6 forces output scale in float formats; overflow clips
// - bits 5-4 select 12+4, 8+4 or fixed point output format
// - bits 3-0 output scale, used in fixed point or when forced
// - map bit set: capture registers present 16 bits of formatted output, or the top 16 comb bits in bypass
// - self-test count sets outputs accumulated; writing it starts self-test
// - memory test started by bit 0 in sleep; fail flags on bits 1, 2
// - map bit clear: capture registers run in signature mode
module cfr_regs #(
	parameter logic [1:0] CHANNEL = 2'h0
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [15:0] wr_data,
	output logic [15:0] rd_data,
	input wire logic map_to_capture,
	input wire logic sleep,
	input wire logic level_indicator_input,
	input wire logic filter_start,
	input wire logic out_strobe,
	input wire logic [23:0] filter_i,
	input wire logic [23:0] filter_q,
	input wire logic [4*24-1:0] comb_i_all,
	input wire logic [4*24-1:0] comb_q_all,
	input wire logic coefficient_memory_fault,
	input wire logic dmem_fault,
	output logic [8:0] resampler_interpolation,
	output logic exp_polarity,
	output logic exp_weight_12db,
	output logic [4:0] resampler_scale_active,
	output logic [7:0] comb_decimation,
	output logic [7:0] comb_scale,
	output logic [7:0] filter_decimation,
	output logic [7:0] filter_phase,
	output logic [7:0] filter_tap_count,
	output logic [7:0] filter_coef_offset,
	output logic [1:0] comb_src_channel,
	output logic coefficient_memory_half,
	output logic filter_bypass,
	output logic memtest_busy,
	output logic selftest_busy
);
	logic [8:0] interp_r;
	logic [11:0] rscale_r;
	logic [7:0] cdec_r;
	logic [7:0] cscale_r;
	logic [7:0] fdec_r;
	logic [7:0] fphase_r;
	logic [7:0] ftaps_r;
	logic [7:0] foffs_r;
	logic [7:0] foffs_work_r;
	logic [7:0] fphase_work_r;
	logic [10:0] fctrl_r;
	logic [15:0] cap_i_r;
	logic [15:0] cap_q_r;
	logic [15:0] stcnt_r;
	logic [15:0] st_left_r;
	logic [2:0] memst_r;
	logic [15:0] mt_cnt_r;
	cfr_pkg::cfr_mt_state_t mt_state_r;
	logic [23:0] src_i;
	logic [23:0] src_q;
	logic [23:0] own_i;
	logic [23:0] own_q;
	logic [15:0] fmt_i;
	logic [15:0] fmt_q;
	logic [15:0] rd_nxt;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic [1:0] fmt;
	logic [3:0] oscale;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			interp_r <= '0;
			rscale_r <= '0;
			cdec_r <= '0;
			cscale_r <= '0;
			fdec_r <= '0;
			fphase_r <= '0;
			ftaps_r <= '0;
			foffs_r <= '0;
			fctrl_r <= '0;
			stcnt_r <= '0;
		end else if (wr_en) begin
			unique case (addr)
				cfr_pkg::ADDR_INTERP: interp_r <= wr_data[8:0];
				cfr_pkg::ADDR_RSCALE: rscale_r <= wr_data[11:0];
				cfr_pkg::ADDR_CDEC: cdec_r <= wr_data[7:0];
				cfr_pkg::ADDR_CSCALE: cscale_r <= wr_data[7:0];
				cfr_pkg::ADDR_FDEC: fdec_r <= wr_data[7:0];
				cfr_pkg::ADDR_FPHASE: fphase_r <= wr_data[7:0];
				cfr_pkg::ADDR_FTAPS: ftaps_r <= wr_data[7:0];
				cfr_pkg::ADDR_FOFFS: foffs_r <= wr_data[7:0];
				cfr_pkg::ADDR_FCTRL: fctrl_r <= wr_data[10:0];
				cfr_pkg::ADDR_STCNT: stcnt_r <= wr_data;
				default: ;
			endcase
		end
	end
	// shadowed offset and phase only move at a filter start so a running filter is undisturbed
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			foffs_work_r <= '0;
			fphase_work_r <= '0;
		end else if (filter_start) begin
			foffs_work_r <= foffs_r;
			fphase_work_r <= fphase_r;
		end
	end
	assign resampler_interpolation = interp_r;
	assign exp_polarity = rscale_r[cfr_pkg::RSC_POL_BIT];
	assign exp_weight_12db = rscale_r[cfr_pkg::RSC_WEIGHT_BIT];
	assign resampler_scale_active = level_indicator_input ?
		rscale_r[cfr_pkg::RSC_HI_MSB:cfr_pkg::RSC_HI_LSB] :
		rscale_r[cfr_pkg::RSC_LO_MSB:cfr_pkg::RSC_LO_LSB];
	assign comb_decimation = cdec_r;
	assign comb_scale = cscale_r;
	assign filter_decimation = fdec_r;
	assign filter_phase = fphase_work_r;
	assign filter_tap_count = ftaps_r;
	assign filter_coef_offset = foffs_work_r;
	assign coefficient_memory_half = fctrl_r[cfr_pkg::CTL_COEFFICIENT_MEMORY_HALF_BIT];
	assign filter_bypass = fctrl_r[cfr_pkg::CTL_BYPASS_BIT];
	always_comb begin
		comb_src_channel = CHANNEL;
		if (fctrl_r[cfr_pkg::CTL_XSRC_BIT]) begin
			comb_src_channel = (CHANNEL == 2'h1) ? 2'h0 : 2'h1;
		end
	end
	assign own_i = comb_i_all[comb_src_channel*24 +: 24];
	assign own_q = comb_q_all[comb_src_channel*24 +: 24];
	assign src_i = filter_bypass ? own_i : filter_i;
	assign src_q = filter_bypass ? own_q : filter_q;
	assign fmt = fctrl_r[cfr_pkg::CTL_FMT_MSB:cfr_pkg::CTL_FMT_LSB];
	assign oscale = fctrl_r[cfr_pkg::CTL_SCALE_MSB:cfr_pkg::CTL_SCALE_LSB];
	function automatic logic [3:0] cfr_lead(input logic [23:0] v);
		logic [23:0] m;
		logic [3:0] e;
		m = v[23] ? ~v : v;
		e = '0;
		for (int k = 0; k < 15; k++) begin
			if (m[k+8]) begin
				e = 4'(k + 1);
			end
		end
		return e;
	endfunction : cfr_lead
	function automatic logic [15:0] cfr_clip(input logic [23:0] v, input logic [3:0] s,
		input logic [4:0] w);
		logic [23:0] sh;
		logic [23:0] lim;
		sh = 24'($signed(v) >>> (4'hF - s)) ;
		lim = (24'h1 << (w - 5'h1)) - 24'h1;
		if ($signed(sh) > $signed(lim)) begin
			sh = lim;
		end else if ($signed(sh) < $signed(~lim)) begin
			sh = ~lim;
		end
		return sh[15:0];
	endfunction : cfr_clip
	always_comb begin
		logic [3:0] ei;
		logic [3:0] eq;
		logic [3:0] es;
		logic [4:0] mw;
		logic [15:0] ci;
		logic [15:0] cq;
		ei = cfr_lead(src_i);
		eq = cfr_lead(src_q);
		es = (ei > eq) ? ei : eq;
		mw = fmt[1] ? 5'hC : 5'h8;
		if (fctrl_r[cfr_pkg::CTL_SHARED_EXP_BIT]) begin
			ei = es;
			eq = es;
		end
		if (fctrl_r[cfr_pkg::CTL_FORCE_SCALE_BIT]) begin
			ei = oscale;
			eq = oscale;
		end
		// a function result cannot be part-selected, so the clipped words land here first
		ci = cfr_clip(src_i, ei, mw);
		cq = cfr_clip(src_q, eq, mw);
		if (filter_bypass) begin
			// bypassed comb data skips the formatter and shows its top sixteen bits
			fmt_i = src_i[23:8];
			fmt_q = src_q[23:8];
		end else if (fmt == cfr_pkg::FMT_FIXED) begin
			fmt_i = cfr_clip(src_i, oscale, 5'h10);
			fmt_q = cfr_clip(src_q, oscale, 5'h10);
		end else if (fmt == cfr_pkg::FMT_8P4) begin
			fmt_i = {4'h0, ci[7:0], ei};
			fmt_q = {4'h0, cq[7:0], eq};
		end else begin
			fmt_i = {ci[11:0], ei};
			fmt_q = {cq[11:0], eq};
		end
	end
	// outputs pass a fifo; it only drains into the map view, one entry per cycle, whether or not the host has read i and q yet
	cfr_fifo #(
		.WIDTH(cfr_pkg::FIFO_WIDTH),
		.DEPTH(cfr_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.in_valid(out_strobe && map_to_capture),
		.in_ready(),
		.in_data({fmt_i, fmt_q}),
		.out_valid(fifo_out_valid),
		.out_ready(map_to_capture),
		.out_data(fifo_out_data)
	);
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cap_i_r <= '0;
			cap_q_r <= '0;
			st_left_r <= '0;
		end else if (map_to_capture) begin
			if (fifo_out_valid) begin
				cap_i_r <= fifo_out_data[31:16];
				cap_q_r <= fifo_out_data[15:0];
			end
		end else if (wr_en && addr == cfr_pkg::ADDR_STCNT) begin
			cap_i_r <= '0;
			cap_q_r <= '0;
			st_left_r <= wr_data;
		end else if (out_strobe && st_left_r != '0) begin
			cap_i_r <= {cap_i_r[14:0], cap_i_r[15] ^ cap_i_r[4]} ^ src_i[23:8];
			cap_q_r <= {cap_q_r[14:0], cap_q_r[15] ^ cap_q_r[4]} ^ src_q[23:8];
			st_left_r <= st_left_r - 16'h1;
		end
	end
	assign selftest_busy = (st_left_r != '0) && !map_to_capture;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mt_state_r <= cfr_pkg::MT_IDLE;
			mt_cnt_r <= '0;
			memst_r <= '0;
		end else begin
			unique case (mt_state_r)
				cfr_pkg::MT_IDLE: begin
					if (wr_en && addr == cfr_pkg::ADDR_MEMST && sleep
						&& wr_data[cfr_pkg::MST_START_BIT]) begin
						mt_state_r <= cfr_pkg::MT_RUN;
						mt_cnt_r <= cfr_pkg::MEMTEST_CNT;
						memst_r <= 3'h1;
					end
				end
				cfr_pkg::MT_RUN: begin
					mt_cnt_r <= mt_cnt_r - 16'h1;
					if (coefficient_memory_fault) begin
						memst_r[cfr_pkg::MST_COEFFICIENT_MEMORY_FAIL_BIT] <= 1'b1;
					end
					if (dmem_fault) begin
						memst_r[cfr_pkg::MST_DMEM_FAIL_BIT] <= 1'b1;
					end
					if (mt_cnt_r == 16'h1) begin
						mt_state_r <= cfr_pkg::MT_IDLE;
						memst_r[cfr_pkg::MST_START_BIT] <= 1'b0;
					end
				end
			endcase
		end
	end
	assign memtest_busy = (mt_state_r == cfr_pkg::MT_RUN);
	always_comb begin
		rd_nxt = '0;
		unique case (addr)
			cfr_pkg::ADDR_INTERP: rd_nxt = {7'h00, interp_r};
			cfr_pkg::ADDR_RSCALE: rd_nxt = {4'h0, rscale_r};
			cfr_pkg::ADDR_CDEC: rd_nxt = {8'h00, cdec_r};
			cfr_pkg::ADDR_CSCALE: rd_nxt = {8'h00, cscale_r};
			cfr_pkg::ADDR_FDEC: rd_nxt = {8'h00, fdec_r};
			cfr_pkg::ADDR_FPHASE: rd_nxt = {8'h00, fphase_r};
			cfr_pkg::ADDR_FTAPS: rd_nxt = {8'h00, ftaps_r};
			cfr_pkg::ADDR_FOFFS: rd_nxt = {8'h00, foffs_r};
			cfr_pkg::ADDR_FCTRL: rd_nxt = {5'h00, fctrl_r};
			cfr_pkg::ADDR_CAP_I: rd_nxt = cap_i_r;
			cfr_pkg::ADDR_CAP_Q: rd_nxt = cap_q_r;
			cfr_pkg::ADDR_STCNT: rd_nxt = stcnt_r;
			cfr_pkg::ADDR_MEMST: rd_nxt = {13'h0000, memst_r};
			default: rd_nxt = '0;
		endcase
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= rd_nxt;
		end
	end
endmodule : cfr_regs
`default_nettype wire

// [tb/cfr_regs_checker.sv]
// port assertions for the channel filter register set
`timescale 1ns/1ns
`default_nettype none
module cfr_regs_checker #(
	parameter logic [1:0] CHANNEL = 2'h0
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic [15:0] rd_data,
	input wire logic sleep,
	input wire logic level_indicator_input,
	input wire logic filter_start,
	input wire logic [8:0] resampler_interpolation,
	input wire logic exp_polarity,
	input wire logic exp_weight_12db,
	input wire logic [4:0] resampler_scale_active,
	input wire logic [7:0] filter_coef_offset,
	input wire logic [1:0] comb_src_channel,
	input wire logic memtest_busy
);
	logic [9:0] rsc_r;
	logic [7:0] off_r;
	logic xsrc_r;
	logic [11:0] busy_cnt_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// shadow copies of the host writes the outputs depend on
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rsc_r <= 10'h000;
			off_r <= 8'h00;
			xsrc_r <= 1'b0;
		end else if (wr_en) begin
			if (addr == cfr_pkg::ADDR_RSCALE) rsc_r <= wr_data[9:0];
			if (addr == cfr_pkg::ADDR_FOFFS) off_r <= wr_data[7:0];
			if (addr == cfr_pkg::ADDR_FCTRL) xsrc_r <= wr_data[9];
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) busy_cnt_r <= 12'h000;
		else busy_cnt_r <= memtest_busy ? busy_cnt_r + 12'h001 : 12'h000;
	end
	sequence s_wr(logic [7:0] a);
		wr_en && addr == a;
	endsequence
	sequence s_mt_go;
		s_wr(cfr_pkg::ADDR_MEMST) ##0 wr_data[0] && sleep && !memtest_busy;
	endsequence
	property p_interp;
		s_wr(cfr_pkg::ADDR_INTERP) |=> resampler_interpolation == $past(wr_data[8:0]);
	endproperty
	a_interp: assert property (p_interp) else $error("interpolation not stored");
	property p_rsc;
		s_wr(cfr_pkg::ADDR_RSCALE) |=> {exp_polarity, exp_weight_12db} == $past(wr_data[11:10]);
	endproperty
	a_rsc: assert property (p_rsc) else $error("exponent bits wrong");
	property p_scale;
		resampler_scale_active == (level_indicator_input ? rsc_r[9:5] : rsc_r[4:0]);
	endproperty
	a_scale: assert property (p_scale) else $error("active scale wrong");
	property p_off_hold;
		!filter_start |=> $stable(filter_coef_offset);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("offset moved");
	property p_off_load;
		filter_start |=> filter_coef_offset == $past(off_r);
	endproperty
	a_off_load: assert property (p_off_load) else $error("offset not loaded");
	property p_src;
		comb_src_channel == (xsrc_r ? (CHANNEL == 2'h1 ? 2'h0 : 2'h1) : CHANNEL);
	endproperty
	a_src: assert property (p_src) else $error("source channel wrong");
	property p_mt_go;
		s_mt_go |=> memtest_busy;
	endproperty
	a_mt_go: assert property (p_mt_go) else $error("memory test not started");
	property p_mt_ref;
		s_wr(cfr_pkg::ADDR_MEMST) ##0 !sleep && !memtest_busy |=> !memtest_busy;
	endproperty
	a_mt_ref: assert property (p_mt_ref) else $error("memory test ran awake");
	property p_mt_len;
		memtest_busy |-> busy_cnt_r < 12'h641;
	endproperty
	a_mt_len: assert property (p_mt_len) else $error("memory test too long");
	property p_rsvd;
		rd_en && (addr == cfr_pkg::ADDR_RSVD_A || addr == cfr_pkg::ADDR_RSVD_B)
			|=> rd_data == 16'h0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
endmodule : cfr_regs_checker
bind cfr_regs cfr_regs_checker #(.CHANNEL(CHANNEL)) i_cfr_regs_checker (
	.clk_sys(clk_sys), .arst_n(arst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
	.wr_data(wr_data), .rd_data(rd_data), .sleep(sleep), .filter_start(filter_start),
	.level_indicator_input(level_indicator_input), .exp_polarity(exp_polarity),
	.resampler_interpolation(resampler_interpolation), .exp_weight_12db(exp_weight_12db),
	.resampler_scale_active(resampler_scale_active), .memtest_busy(memtest_busy),
	.filter_coef_offset(filter_coef_offset), .comb_src_channel(comb_src_channel));
`default_nettype wire

// [tb/cfr_host.sv]
// host model making register writes and reads
`timescale 1ns/1ns
`default_nettype none
module cfr_host (
	input wire logic clk_sys,
	input wire logic [15:0] rd_data,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [15:0] wr_data
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wr_data = 16'h0000;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		// reserved places only ever get zeros
		wr_data <= (a == cfr_pkg::ADDR_RSVD_A || a == cfr_pkg::ADDR_RSVD_B) ? 16'h0000 : d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		// released bus shows no stale value
		wr_data <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(posedge clk_sys);
		#1 d = rd_data;
	endtask : rd
endmodule : cfr_host
`default_nettype wire

// [tb/cfr_regs_bench.sv]
// self-checking bench for the channel filter register set
`timescale 1ns/1ns
`default_nettype none
module cfr_regs_bench;
	logic clk_sys, arst_n, wr_en, rd_en, map_to_capture, sleep, level_indicator_input;
	logic filter_start, out_strobe, coefficient_memory_fault, dmem_fault;
	logic exp_polarity, exp_weight_12db, coefficient_memory_half, filter_bypass, memtest_busy, selftest_busy;
	logic [7:0] addr, filter_phase, filter_coef_offset;
	logic [7:0] comb_decimation, comb_scale, filter_decimation, filter_tap_count;
	logic [15:0] wr_data, rd_data, v, w;
	logic [23:0] filter_i, filter_q;
	logic [95:0] comb_i_all, comb_q_all;
	logic [4:0] resampler_scale_active;
	logic [1:0] comb_src_channel;
	int fail_count = 0;
	int checks_done = 0;
	int n;
	// address, written value, value read back
	// interpolation 0x1FF presumes a larger resampler decimation set outside this block
	logic [39:0] rows [0:12] = '{40'h91FFFF01FF, 40'h92FFFF0FFF, 40'h9300000000,
		40'h94FFFF00FF, 40'h95FFFF00FF, 40'h9600000000, 40'hA0FFFF00FF, 40'hA1FFFF00FF,
		40'hA2FFFF00FF, 40'hA3FFFF00FF, 40'hA4FFFF07FF, 40'hA700100010, 40'hB0FFFF0000};
	cfr_host i_cfr_host (.clk_sys(clk_sys), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wr_data(wr_data));
	cfr_regs #(.CHANNEL(2'h2)) i_cfr_regs (.clk_sys(clk_sys), .arst_n(arst_n),
		.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
		.map_to_capture(map_to_capture), .sleep(sleep), .filter_start(filter_start),
		.level_indicator_input(level_indicator_input), .out_strobe(out_strobe),
		.filter_i(filter_i), .filter_q(filter_q), .comb_i_all(comb_i_all),
		.comb_q_all(comb_q_all), .coefficient_memory_fault(coefficient_memory_fault), .dmem_fault(dmem_fault),
		.resampler_interpolation(), .exp_polarity(exp_polarity),
		.exp_weight_12db(exp_weight_12db), .resampler_scale_active(resampler_scale_active),
		.comb_decimation(comb_decimation), .comb_scale(comb_scale),
		.filter_decimation(filter_decimation), .filter_phase(filter_phase),
		.filter_tap_count(filter_tap_count), .filter_coef_offset(filter_coef_offset),
		.comb_src_channel(comb_src_channel), .coefficient_memory_half(coefficient_memory_half),
		.filter_bypass(filter_bypass), .memtest_busy(memtest_busy),
		.selftest_busy(selftest_busy));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one output pushed through the map view, then read back as i and q
	task automatic cap_pair(input logic [15:0] ctl, input logic [23:0] di, input logic [23:0] dq,
		output logic [15:0] ci, output logic [15:0] cq);
		i_cfr_host.wr(cfr_pkg::ADDR_FCTRL, ctl);
		filter_i <= di;
		filter_q <= dq;
		@(posedge clk_sys);
		out_strobe <= 1'b1;
		@(posedge clk_sys);
		out_strobe <= 1'b0;
		i_cfr_host.rd(cfr_pkg::ADDR_CAP_I, ci);
		i_cfr_host.rd(cfr_pkg::ADDR_CAP_Q, cq);
	endtask : cap_pair
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// a hang is cut short here rather than left to run
	initial begin
		repeat (10000) @(posedge clk_sys);
		fail_count++;
		end_of_test();
	end
	initial begin
		{arst_n, map_to_capture, sleep, level_indicator_input} = 4'h0;
		{filter_start, out_strobe, coefficient_memory_fault, dmem_fault} = 4'h0;
		{filter_i, filter_q, comb_i_all, comb_q_all} = '0;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		for (int i = 0; i < 13; i++) begin
			i_cfr_host.rd(rows[i][39:32], v);
			chk(v, 16'h0000);
			i_cfr_host.wr(rows[i][39:32], rows[i][31:16]);
			i_cfr_host.rd(rows[i][39:32], v);
			chk(v, rows[i][15:0]);
		end
		chk({comb_decimation, comb_scale}, 16'hFFFF);
		chk({filter_decimation, filter_tap_count}, 16'hFFFF);
		i_cfr_host.wr(cfr_pkg::ADDR_RSCALE, 16'h0EAA);
		for (int k = 1; k >= 0; k--) begin
			level_indicator_input <= k[0];
			@(posedge clk_sys);
			#1 chk({11'h000, resampler_scale_active}, k ? 16'h0015 : 16'h000A);
			chk({14'h0000, exp_polarity, exp_weight_12db}, 16'h0003);
			@(posedge clk_sys);
		end
		i_cfr_host.wr(cfr_pkg::ADDR_FCTRL, 16'h0700);
		@(posedge clk_sys);
		#1 chk({12'h000, filter_bypass, coefficient_memory_half, comb_src_channel}, 16'h000D);
		i_cfr_host.wr(cfr_pkg::ADDR_FCTRL, 16'h0000);
		@(posedge clk_sys);
		#1 chk({12'h000, filter_bypass, coefficient_memory_half, comb_src_channel}, 16'h0002);
		for (int f = 0; f < 4; f++) begin
			i_cfr_host.wr(cfr_pkg::ADDR_FCTRL, 16'(f * 16 + 16'h00C5));
			i_cfr_host.rd(cfr_pkg::ADDR_FCTRL, v);
			chk(v, 16'(f * 16 + 16'h00C5));
		end
		i_cfr_host.wr(cfr_pkg::ADDR_FOFFS, 16'h005A);
		i_cfr_host.wr(cfr_pkg::ADDR_FPHASE, 16'h0003);
		@(posedge clk_sys);
		#1 chk({filter_phase, filter_coef_offset}, 16'h0000);
		@(posedge clk_sys);
		filter_start <= 1'b1;
		@(posedge clk_sys);
		filter_start <= 1'b0;
		#1 chk({filter_phase, filter_coef_offset}, 16'h035A);
		i_cfr_host.wr(cfr_pkg::ADDR_FCTRL, 16'h0400);
		map_to_capture <= 1'b1;
		comb_i_all[71:48] <= 24'hABCDEF;
		comb_q_all[71:48] <= 24'h123456;
		@(posedge clk_sys);
		out_strobe <= 1'b1;
		@(posedge clk_sys);
		out_strobe <= 1'b0;
		n = 0;
		do begin
			i_cfr_host.rd(cfr_pkg::ADDR_CAP_I, v);
			n++;
		end while (v !== 16'hABCD && n < 8);
		chk(v, 16'hABCD);
		if (v !== 16'hABCD) end_of_test();
		i_cfr_host.rd(cfr_pkg::ADDR_CAP_Q, v);
		chk(v, 16'h1234);
		// full-scale inputs at the largest scale must clip, never wrap
		cap_pair(16'h000F, 24'h7FFFFF, 24'h800000, v, w);
		chk(v, 16'h7FFF);
		chk(w, 16'h8000);
		cap_pair(16'h0090, 24'h7FFFFF, 24'h000100, v, w);
		chk({15'h0000, v[3:0] == w[3:0]}, 16'h0001);
		cap_pair(16'h0010, 24'h7FFFFF, 24'h000100, v, w);
		chk({15'h0000, v[3:0] == w[3:0]}, 16'h0000);
		map_to_capture <= 1'b0;
		i_cfr_host.wr(cfr_pkg::ADDR_STCNT, 16'h0003);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			#1 chk({15'h0000, selftest_busy}, 16'h0001);
			@(posedge clk_sys);
			out_strobe <= 1'b1;
			@(posedge clk_sys);
			out_strobe <= 1'b0;
		end
		@(posedge clk_sys);
		#1 chk({15'h0000, selftest_busy}, 16'h0000);
		// a second reset in mid-run clears settings and the shadowed pointer alike
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		#1 chk({filter_phase, filter_coef_offset}, 16'h0000);
		i_cfr_host.rd(cfr_pkg::ADDR_FCTRL, v);
		chk(v, 16'h0000);
		i_cfr_host.wr(cfr_pkg::ADDR_MEMST, 16'h0001);
		i_cfr_host.rd(cfr_pkg::ADDR_MEMST, v);
		chk(v, 16'h0000);
		sleep <= 1'b1;
		dmem_fault <= 1'b1;
		i_cfr_host.wr(cfr_pkg::ADDR_MEMST, 16'h0001);
		// the host leaves the register alone until the full test time has passed
		@(posedge clk_sys);
		#1 chk({15'h0000, memtest_busy}, 16'h0001);
		repeat (1600) @(posedge clk_sys);
		#1 chk({15'h0000, memtest_busy}, 16'h0000);
		i_cfr_host.rd(cfr_pkg::ADDR_MEMST, v);
		chk(v, 16'h0004);
		end_of_test();
	end
endmodule : cfr_regs_bench
`default_nettype wire
